// ### shared/dap_pkg.sv
// constants shared by the debug-port eprom access registers
// assumes a link engine on sys_clk that decodes target-select and data commands
package dap_pkg;

    // debug target codes of the registers in this block
    localparam logic [7:0] SEL_CRC_B0  = 8'ha9;
    localparam logic [7:0] SEL_CRC_B1  = 8'haa;
    localparam logic [7:0] SEL_CRC_B2  = 8'hab;
    localparam logic [7:0] SEL_CRC_B3  = 8'hac;
    localparam logic [7:0] SEL_ADDR_LO = 8'hae;
    localparam logic [7:0] SEL_ADDR_HI = 8'haf;
    localparam logic [7:0] SEL_STATUS  = 8'hb7;
    localparam logic [7:0] SEL_DATA    = 8'hbf;
    localparam logic [7:0] SEL_CTRL    = 8'hdf;

    // status field positions and register reset value
    localparam int         ST_WPROT_BIT  = 7;
    localparam int         ST_RPROT_BIT  = 6;
    localparam int         ST_ERR_BIT    = 0;
    localparam logic [7:0] REG_RST       = 8'h00;

    // crc block geometry
    localparam logic [16:0] BLOCK_BYTES    = 17'h00100;
    localparam logic [7:0]  BLOCK_LOW_ADDR = 8'h00;
    localparam int unsigned PROG_BYTES_DEF = 65536;

    // crc polynomials, seeds and final inversion
    localparam logic [15:0] CRC16_POLY   = 16'h1021;
    localparam logic [15:0] CRC16_INIT   = 16'h0000;
    localparam logic [31:0] CRC32_POLY   = 32'h04c11db7;
    localparam logic [31:0] CRC32_INIT   = 32'hffffffff;
    localparam logic [31:0] CRC32_XOROUT = 32'hffffffff;

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_MEM_RD,
        ST_MEM_CAP,
        ST_CRC_RD,
        ST_CRC_WAIT,
        ST_CRC_ACC
    } dap_state_e;

endpackage

// ### logic/dap_eprom_access_regs.sv
// eprom access register set reached through the two-wire debug link
// assumes a link engine on sys_clk giving one-cycle command strobes, an
// eprom with one-cycle registered read, and security logic that answers
// combinationally for the address on eprom_location
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - control byte at 0xdf, reset zero, nonzero value enables programming.
// - data byte at 0xbf, reset zero, carries written and read eprom bytes.
// - status bit 7 shows write protection of the current location.
// - status bit 6 shows read protection of the current location.
// - status bits 5 to 1 read zero, writes ignored.
// - status bit 0 set when last eprom access was refused for security.
// - location high byte 0xaf, low byte 0xae, both reset zero.
// - write to crc byte 0 at 0xa9 starts 16-bit crc of 256 bytes.
// - written byte is start address high byte, low byte forced to zero.
// - 16-bit result: high byte in crc byte 1, low byte in crc byte 0.
// - target-select load picks the register for data read and write.
// - write to crc byte 1 starts 32-bit crc of PROG_BYTES bytes from zero.
module dap_eprom_access_regs #(
    parameter int unsigned PROG_BYTES = dap_pkg::PROG_BYTES_DEF
) (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        sel_wr,
    input  wire logic        data_wr,
    input  wire logic        data_rd,
    input  wire logic [7:0]  link_wdata,
    output logic      [7:0]  link_rdata,
    output logic             link_rvalid,
    output logic             busy,
    output logic      [7:0]  program_control,
    output logic      [15:0] eprom_location,
    input  wire logic        write_protect_flag,
    input  wire logic        read_protect_flag,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata
);
    import dap_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state

    dap_state_e  state_q, state_d;
    logic [7:0]  sel_q, sel_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  data_q, data_d;
    logic [7:0]  hi_q, hi_d;
    logic [7:0]  lo_q, lo_d;
    logic        err_q, err_d;
    logic [31:0] crc_q, crc_d;
    logic        wide_q, wide_d;
    logic [16:0] cnt_q, cnt_d;
    logic [16:0] len_q, len_d;
    logic [15:0] maddr_q, maddr_d;
    logic        mrd_q, mrd_d;
    logic        mwr_q, mwr_d;
    logic [7:0]  mwdata_q, mwdata_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        rvalid_q, rvalid_d;
    logic        busy_q, busy_d;
    logic [15:0] crc16_nx;
    logic [31:0] crc32_nx;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // msb-first crc steps, one byte per call
    function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                               input logic [7:0]  b);
        logic [15:0] r;
        r = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            r = r[15] ? ((r << 1) ^ CRC16_POLY) : (r << 1);
        end
        return r;
    endfunction

    function automatic logic [31:0] crc32_step(input logic [31:0] c,
                                               input logic [7:0]  b);
        logic [31:0] r;
        r = c ^ {b, 24'h000000};
        for (int i = 0; i < 8; i++)
        begin
            r = r[31] ? ((r << 1) ^ CRC32_POLY) : (r << 1);
        end
        return r;
    endfunction

    // register read mux; unknown targets answer zero
    function automatic logic [7:0] read_mux(input logic [7:0] s);
        logic [7:0] v;
        v = REG_RST;
        case (s)
            SEL_CTRL:    v = ctrl_q;
            SEL_DATA:    v = data_q;
            SEL_ADDR_HI: v = hi_q;
            SEL_ADDR_LO: v = lo_q;
            SEL_CRC_B0:  v = crc_q[7:0];
            SEL_CRC_B1:  v = crc_q[15:8];
            SEL_CRC_B2:  v = crc_q[23:16];
            SEL_CRC_B3:  v = crc_q[31:24];
            SEL_STATUS:
            begin
                v[ST_WPROT_BIT] = write_protect_flag;
                v[ST_RPROT_BIT] = read_protect_flag;
                v[ST_ERR_BIT]   = err_q;
            end
            default: v = REG_RST;
        endcase
        return v;
    endfunction

    assign crc16_nx = crc16_step(crc_q[15:0], mem_rdata);
    assign crc32_nx = crc32_step(crc_q, mem_rdata);

    ////////////////////////////////////////////////////////////////////
    // next-state logic; commands arriving while busy are dropped

    always_comb
    begin
        state_d  = state_q;
        sel_d    = sel_q;
        ctrl_d   = ctrl_q;
        data_d   = data_q;
        hi_d     = hi_q;
        lo_d     = lo_q;
        err_d    = err_q;
        crc_d    = crc_q;
        wide_d   = wide_q;
        cnt_d    = cnt_q;
        len_d    = len_q;
        maddr_d  = maddr_q;
        mrd_d    = 1'b0;
        mwr_d    = 1'b0;
        mwdata_d = mwdata_q;
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        unique case (state_q)
            ST_IDLE:
            begin
                if (sel_wr)
                begin
                    sel_d = link_wdata;
                end
                else if (data_wr)
                begin
                    // status is read-only, its writes fall to default
                    case (sel_q)
                        SEL_CTRL: ctrl_d = link_wdata;
                        SEL_ADDR_HI: hi_d = link_wdata;
                        SEL_ADDR_LO: lo_d = link_wdata;
                        SEL_DATA:
                        begin
                            data_d = link_wdata;
                            if (ctrl_q != REG_RST)
                            begin
                                if (write_protect_flag)
                                begin
                                    err_d = 1'b1;
                                end
                                else
                                begin
                                    err_d    = 1'b0;
                                    maddr_d  = {hi_q, lo_q};
                                    mwdata_d = link_wdata;
                                    mwr_d    = 1'b1;
                                end
                            end
                        end
                        SEL_CRC_B0:
                        begin
                            crc_d   = {16'h0000, CRC16_INIT};
                            maddr_d = {link_wdata, BLOCK_LOW_ADDR};
                            cnt_d   = 17'h00000;
                            len_d   = BLOCK_BYTES;
                            wide_d  = 1'b0;
                            state_d = ST_CRC_RD;
                        end
                        SEL_CRC_B1:
                        begin
                            crc_d   = CRC32_INIT;
                            maddr_d = 16'h0000;
                            cnt_d   = 17'h00000;
                            len_d   = 17'(PROG_BYTES);
                            wide_d  = 1'b1;
                            state_d = ST_CRC_RD;
                        end
                        SEL_CRC_B2: crc_d[23:16] = link_wdata;
                        SEL_CRC_B3: crc_d[31:24] = link_wdata;
                        default: ;
                    endcase
                end
                else if (data_rd)
                begin
                    if (sel_q == SEL_DATA && !read_protect_flag)
                    begin
                        err_d   = 1'b0;
                        maddr_d = {hi_q, lo_q};
                        mrd_d   = 1'b1;
                        state_d = ST_MEM_RD;
                    end
                    else
                    begin
                        // refused data read returns the stale byte
                        if (sel_q == SEL_DATA)
                        begin
                            err_d = 1'b1;
                        end
                        rdata_d  = read_mux(sel_q);
                        rvalid_d = 1'b1;
                    end
                end
            end
            ST_MEM_RD: state_d = ST_MEM_CAP;
            ST_MEM_CAP:
            begin
                data_d   = mem_rdata;
                rdata_d  = mem_rdata;
                rvalid_d = 1'b1;
                state_d  = ST_IDLE;
            end
            ST_CRC_RD:
            begin
                mrd_d   = 1'b1;
                state_d = ST_CRC_WAIT;
            end
            ST_CRC_WAIT: state_d = ST_CRC_ACC;
            ST_CRC_ACC:
            begin
                cnt_d   = cnt_q + 17'h00001;
                maddr_d = maddr_q + 16'h0001;
                crc_d   = wide_q ? crc32_nx : {16'h0000, crc16_nx};
                state_d = ST_CRC_RD;
                if (cnt_d == len_q)
                begin
                    // 16-bit result sits in bytes 1 and 0
                    crc_d   = wide_q ? (crc32_nx ^ CRC32_XOROUT)
                                     : {16'h0000, crc16_nx};
                    state_d = ST_IDLE;
                end
            end
        endcase
        busy_d = (state_d != ST_IDLE);
    end

    ////////////////////////////////////////////////////////////////////
    // registers; everything clears on a sys_clk rising edge while rstn is low

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            state_q  <= ST_IDLE;
            sel_q    <= REG_RST;
            ctrl_q   <= REG_RST;
            data_q   <= REG_RST;
            hi_q     <= REG_RST;
            lo_q     <= REG_RST;
            err_q    <= 1'b0;
            crc_q    <= 32'h00000000;
            wide_q   <= 1'b0;
            cnt_q    <= 17'h00000;
            len_q    <= 17'h00000;
            maddr_q  <= 16'h0000;
            mrd_q    <= 1'b0;
            mwr_q    <= 1'b0;
            mwdata_q <= REG_RST;
            rdata_q  <= REG_RST;
            rvalid_q <= 1'b0;
            busy_q   <= 1'b0;
        end
        else
        begin
            state_q  <= state_d;
            sel_q    <= sel_d;
            ctrl_q   <= ctrl_d;
            data_q   <= data_d;
            hi_q     <= hi_d;
            lo_q     <= lo_d;
            err_q    <= err_d;
            crc_q    <= crc_d;
            wide_q   <= wide_d;
            cnt_q    <= cnt_d;
            len_q    <= len_d;
            maddr_q  <= maddr_d;
            mrd_q    <= mrd_d;
            mwr_q    <= mwr_d;
            mwdata_q <= mwdata_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            busy_q   <= busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign link_rdata      = rdata_q;
    assign link_rvalid     = rvalid_q;
    assign busy            = busy_q;
    assign program_control = ctrl_q;
    assign eprom_location  = {hi_q, lo_q};
    assign mem_addr        = maddr_q;
    assign mem_rd          = mrd_q;
    assign mem_wr          = mwr_q;
    assign mem_wdata       = mwdata_q;

endmodule // dap_eprom_access_regs

`default_nettype wire

// ### verification/dap_eprom_model.sv
// eprom and lock stand-in on the far side of the access registers
// assumes one-cycle registered reads; page f write-locked, page e read-locked
`timescale 1ns/1ps
`default_nettype none
module dap_eprom_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    input  wire logic [15:0] eprom_location,
    output logic             write_protect_flag,
    output logic             read_protect_flag,
    output logic      [7:0]  mem_rdata,
    output logic      [7:0]  wr_cnt,
    output logic      [7:0]  wr_data
);
    // contents are a fixed pattern, so no array is modelled
    function automatic logic [7:0] pat_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction
    // locks answer at once for the current location
    assign write_protect_flag = (eprom_location[15:12] == 4'hf);
    assign read_protect_flag  = (eprom_location[15:12] == 4'he);
    initial
    begin
        mem_rdata = 8'h00;
        wr_cnt    = 8'h00;
        wr_data   = 8'h00;
    end
    // outside a read the bus toggles so stale data never passes for an answer
    always @(posedge sys_clk)
    begin
        mem_rdata <= mem_rd ? pat_byte(mem_addr) : ~mem_rdata;
        if (mem_wr)
        begin
            wr_cnt  <= wr_cnt + 8'h01;
            wr_data <= mem_wdata;
        end
    end
endmodule // dap_eprom_model
`default_nettype wire

// ### verification/dap_regs_chk.sv
// port assertions for the eprom access registers
// assumes one clock and no overlapping link strobes
`timescale 1ns/1ps
`default_nettype none
module dap_regs_chk
    import dap_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        sel_wr,
    input wire logic        data_wr,
    input wire logic        data_rd,
    input wire logic [7:0]  link_wdata,
    input wire logic [7:0]  link_rdata,
    input wire logic        link_rvalid,
    input wire logic        busy,
    input wire logic [7:0]  program_control,
    input wire logic [15:0] eprom_location,
    input wire logic        write_protect_flag,
    input wire logic        read_protect_flag,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata
);
    logic [7:0] tsel_q;
    logic [7:0] tsel_d;
    logic       tk_wr;
    logic       tk_rd;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow of the target select, since the design does not show it
    always_comb
    begin
        tsel_d = (sel_wr && !busy) ? link_wdata : tsel_q;
    end
    always_ff @(posedge sys_clk)
    begin
        tsel_q <= rstn ? tsel_d : REG_RST;
    end
    assign tk_wr = data_wr && !sel_wr && !busy;
    assign tk_rd = data_rd && !sel_wr && !data_wr && !busy;
    sequence rd_walk_s;
        mem_rd ##1 !mem_rd ##1 link_rvalid;
    endsequence
    // busy rises at once, the first memory read of a crc follows one cycle later
    sequence crc_go_s;
        busy && !mem_rd ##1 busy && mem_rd;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    ctrl_load_a: assert property (tk_wr && tsel_q == SEL_CTRL
        |=> program_control == $past(link_wdata)) else $error("control not loaded");
    addr_low_a: assert property (tk_wr && tsel_q == SEL_ADDR_LO
        |=> eprom_location == {$past(eprom_location[15:8]), $past(link_wdata)})
        else $error("location low not loaded");
    prog_write_a: assert property (tk_wr && tsel_q == SEL_DATA && program_control != 8'h00
        && !write_protect_flag |=> mem_wr && mem_wdata == $past(link_wdata)
        && mem_addr == $past(eprom_location)) else $error("program write wrong");
    no_prog_a: assert property (tk_wr && tsel_q == SEL_DATA
        && (program_control == 8'h00 || write_protect_flag) |=> !mem_wr)
        else $error("refused write reached memory");
    data_read_a: assert property (tk_rd && tsel_q == SEL_DATA && !read_protect_flag
        |=> mem_addr == $past(eprom_location) ##0 rd_walk_s ##0 link_rdata == $past(mem_rdata))
        else $error("data read walk wrong");
    lock_read_a: assert property (tk_rd && tsel_q == SEL_DATA && read_protect_flag
        |=> link_rvalid && !mem_rd) else $error("locked read not refused");
    block_crc_a: assert property (tk_wr && tsel_q == SEL_CRC_B0
        |=> mem_addr == {$past(link_wdata), BLOCK_LOW_ADDR} ##0 crc_go_s)
        else $error("block crc start wrong");
    full_crc_a: assert property (tk_wr && tsel_q == SEL_CRC_B1
        |=> mem_addr == 16'h0000 ##0 crc_go_s) else $error("full crc start wrong");
endmodule // dap_regs_chk
bind dap_eprom_access_regs dap_regs_chk u_chk (.sys_clk, .rstn, .sel_wr, .data_wr, .data_rd,
    .link_wdata, .link_rdata, .link_rvalid, .busy, .program_control, .eprom_location,
    .write_protect_flag, .read_protect_flag, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench: link command tasks against the access registers
// assumes the eprom model's pattern contents and lock map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dap_pkg::*;
    localparam int unsigned PB = 512;
    logic        sys_clk, rstn, sel_wr, data_wr, data_rd, link_rvalid, busy, mem_rd, mem_wr;
    logic        write_protect_flag, read_protect_flag;
    logic [7:0]  link_wdata, link_rdata, program_control, mem_wdata, mem_rdata, wr_cnt, wr_data;
    logic [15:0] eprom_location, mem_addr;
    logic [31:0] crc_exp;
    logic [7:0]  rst_t [8] = '{SEL_CTRL, SEL_STATUS, SEL_ADDR_HI, SEL_ADDR_LO, SEL_CRC_B0,
                               SEL_CRC_B1, SEL_CRC_B3, 8'h03};
    int          err_count = 0;
    int          total_checks = 0;
    dap_eprom_access_regs #(.PROG_BYTES(PB)) dut (.sys_clk, .rstn, .sel_wr, .data_wr, .data_rd,
        .link_wdata, .link_rdata, .link_rvalid, .busy, .program_control, .eprom_location,
        .write_protect_flag, .read_protect_flag, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
        .mem_rdata);
    dap_eprom_model mem (.sys_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .eprom_location,
        .write_protect_flag, .read_protect_flag, .mem_rdata, .wr_cnt, .wr_data);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait on a level; a hang counts as a mismatch and ends the run
    task automatic wait_lvl(input int lim, input logic want_valid);
        int n;
        n = 0;
        while (want_valid ? link_rvalid !== 1'b1 : busy !== 1'b0)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > lim)
            begin
                err_count++;
                print_verdict();
            end
        end
    endtask
    // one strobe for one cycle, offered only while idle; an idle edge first so a
    // strobe is never dropped and raised in one time step
    task automatic drive(input logic [2:0] k, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        wait_lvl(4000, 1'b0);
        {sel_wr, data_wr, data_rd} = k;
        link_wdata = d;
        @(posedge sys_clk);
        #1;
        {sel_wr, data_wr, data_rd} = 3'b000;
    endtask
    task automatic wreg(input logic [7:0] t, input logic [7:0] d);
        drive(3'b100, t);
        drive(3'b010, d);
    endtask
    task automatic rchk(input logic [7:0] t, input logic [7:0] exp);
        drive(3'b100, t);
        drive(3'b001, 8'h00);
        wait_lvl(8, 1'b1);
        check({24'h0, link_rdata}, {24'h0, exp});
    endtask
    // reference crc, msb first, over the model's pattern
    function automatic logic [31:0] crc_ref(input logic [15:0] a0, input int n, input logic w);
        logic [31:0] c;
        logic [7:0]  b;
        c = w ? CRC32_INIT : {16'h0000, CRC16_INIT};
        for (int i = 0; i < n; i++)
        begin
            b = mem.pat_byte(a0 + 16'(i));
            for (int k = 7; k >= 0; k--)
                if (w)
                    c = {c[30:0], 1'b0} ^ ((c[31] ^ b[k]) ? CRC32_POLY : 32'h0);
                else
                    c[15:0] = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? CRC16_POLY : 16'h0);
        end
        return w ? c ^ CRC32_XOROUT : {16'h0000, c[15:0]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial
    begin
        {rstn, sel_wr, data_wr, data_rd, link_wdata} = 12'h000;
        repeat (2) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        foreach (rst_t[i]) rchk(rst_t[i], 8'h00);
        $display("test reset values done");
        wreg(SEL_ADDR_HI, 8'hf0);
        wreg(SEL_ADDR_LO, 8'h12);
        rchk(SEL_ADDR_LO, 8'h12);
        rchk(SEL_ADDR_HI, 8'hf0);
        rchk(SEL_STATUS, 8'h80);
        wreg(SEL_STATUS, 8'hff);
        wreg(SEL_ADDR_HI, 8'he0);
        rchk(SEL_STATUS, 8'h40);
        rchk(SEL_DATA, 8'h00);
        rchk(SEL_STATUS, 8'h41);
        $display("test locks done");
        wreg(SEL_ADDR_HI, 8'h12);
        wreg(SEL_ADDR_LO, 8'h34);
        rchk(SEL_DATA, mem.pat_byte(16'h1234));
        rchk(SEL_STATUS, 8'h00);
        wreg(SEL_DATA, 8'h5a);
        rchk(SEL_CTRL, 8'h00);
        check({24'h0, wr_cnt}, 32'h0);
        wreg(SEL_CTRL, 8'h01);
        wreg(SEL_DATA, 8'ha5);
        rchk(SEL_CTRL, 8'h01);
        check({16'h0, wr_cnt, wr_data}, 32'h01a5);
        wreg(SEL_ADDR_HI, 8'hf0);
        wreg(SEL_DATA, 8'h3c);
        rchk(SEL_STATUS, 8'h81);
        check({24'h0, wr_cnt}, 32'h1);
        $display("test data port done");
        wreg(SEL_CRC_B0, 8'h12);
        crc_exp = crc_ref(16'h1200, 256, 1'b0);
        rchk(SEL_CRC_B0, crc_exp[7:0]);
        rchk(SEL_CRC_B1, crc_exp[15:8]);
        rchk(SEL_CRC_B2, 8'h00);
        wreg(SEL_CRC_B1, 8'h00);
        crc_exp = crc_ref(16'h0000, PB, 1'b1);
        for (int i = 0; i < 4; i++) rchk(SEL_CRC_B0 + 8'(i), crc_exp[8*i +: 8]);
        $display("test crc done");
        // a reset in the middle of a PB-byte crc from address zero stops it and clears the registers
        wreg(SEL_CRC_B1, 8'h00);
        repeat (20) @(posedge sys_clk);
        #1;
        check({31'h0, busy}, 32'h1);
        rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({31'h0, busy}, 32'h0);
        rstn = 1'b1;
        rchk(SEL_CTRL, 8'h00);
        rchk(SEL_ADDR_HI, 8'h00);
        rchk(SEL_CRC_B1, 8'h00);
        $display("test reset mid-run done");
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
